// ### include/sbsm_defines.vh
// Constants for the serial baud generator and shift-mode block
`ifndef SBSM_DEFINES_VH
`define SBSM_DEFINES_VH

// Register byte offsets
`define SBSM_OFF_CTRL 5'h00
`define SBSM_OFF_STATUS 5'h04
`define SBSM_OFF_DATA 5'h08
`define SBSM_OFF_T2COUNT 5'h0C
`define SBSM_OFF_T2RELOAD 5'h10

// Control register fields
`define SBSM_CTRL_MODE_LO 0
`define SBSM_CTRL_MODE_HI 1
`define SBSM_CTRL_RX_EN 2
`define SBSM_CTRL_DOUBLE 3
`define SBSM_CTRL_TX_SEL 4
`define SBSM_CTRL_RX_SEL 5
`define SBSM_CTRL_T2_RUN 6
`define SBSM_CTRL_T2_CNT 7
`define SBSM_CTRL_T2_EXEN 8
`define SBSM_CTRL_RESET 9'h000

// Status register fields
`define SBSM_ST_RX_DONE 0
`define SBSM_ST_TX_DONE 1
`define SBSM_ST_T2_OVF 2
`define SBSM_ST_T2_EXT 3
`define SBSM_ST_TX_ACT 4
`define SBSM_ST_RX_ACT 5

// Serial modes
`define SBSM_MODE_SHIFT 2'h0
`define SBSM_MODE_VAR8 2'h1
`define SBSM_MODE_FIX9 2'h2
`define SBSM_MODE_VAR9 2'h3

// Machine cycle phases, S1P1 = 0 .. S6P2 = 11
`define SBSM_PH_S1P1 4'h0
`define SBSM_PH_S2P2 4'h3
`define SBSM_PH_S5P1 4'h8
`define SBSM_PH_S5P2 4'h9
`define SBSM_PH_S6P2 4'hB
`define SBSM_PH_LAST 4'hB

// Bit-rate divisors
`define SBSM_DIV_FIX_SLOW 7'h40
`define SBSM_DIV_FIX_FAST 7'h20
`define SBSM_DIV_T1_SLOW 7'h20
`define SBSM_DIV_T1_FAST 7'h10
`define SBSM_DIV_T2 7'h10
`define SBSM_DIV_SHIFT 7'h01

// Shift register start patterns
`define SBSM_TX_MARK 1'h1
`define SBSM_RX_FILL 8'hFE

`endif

// ### rtl/sbsm_phase.v
// Machine cycle state and phase counter
`timescale 1ns/100ps
`include "sbsm_defines.vh"

module sbsm_phase (
  input wire core_clk, // Oscillator clock
  input wire nrst, // Async reset, active low
  output reg [3:0] phase_q, // Current phase, 0 = S1P1
  output reg state_tick_q, // High in P2 of every state
  output reg cycle_tick_q // High during S6P2
);
  reg [3:0] phase_d;

  always @* begin
    if (phase_q == `SBSM_PH_LAST) begin
      phase_d = 4'h0;
    end else begin
      phase_d = phase_q + 4'h1;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 4'h0;
      state_tick_q <= 1'b0;
      cycle_tick_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      state_tick_q <= phase_d[0];
      cycle_tick_q <= (phase_d == `SBSM_PH_S6P2);
    end
  end
endmodule // sbsm_phase

// ### rtl/sbsm_timer2.v
// Timer 2 with auto-reload and bit-rate generator operation
`timescale 1ns/100ps
`include "sbsm_defines.vh"

module sbsm_timer2 (
  input wire core_clk, // Oscillator clock
  input wire nrst, // Async reset, active low
  input wire state_tick, // One pulse per state time
  input wire cycle_tick, // One pulse per machine cycle
  input wire baud_mode, // Either clock select bit set
  input wire run, // timer2_run
  input wire count_select, // timer2_count_select
  input wire ext_enable, // timer2_external_enable
  input wire ext_fall, // Falling edge on external input
  input wire count_fall, // Falling edge on count input
  input wire wr_count, // Software writes the count
  input wire wr_reload, // Software writes the reload value
  input wire [15:0] wdata, // Write data
  input wire clr_ovf, // Clear overflow flag
  input wire clr_ext, // Clear external flag
  output reg [15:0] count_q, // Timer count, high:low
  output reg [15:0] reload_q, // reload_capture_high:low
  output reg ovf_pulse_q, // Rollover pulse
  output reg ovf_flag_q, // timer2_overflow_flag
  output reg ext_flag_q // timer2_external_flag
);
  wire inc;
  wire roll;
  wire ext_reload;

  // Count select counts pin edges, else baud mode counts state times, else machine cycles
  assign inc = run & (count_select ? count_fall :
    (baud_mode ? state_tick : cycle_tick)); // see RULE10
  assign roll = inc & (count_q == 16'hFFFF);
  assign ext_reload = ext_enable & ext_fall & ~baud_mode; // see RULE12

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 16'h0000;
      reload_q <= 16'h0000;
      ovf_pulse_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      ext_flag_q <= 1'b0;
    end else begin
      ovf_pulse_q <= roll;
      if (roll || ext_reload) begin
        count_q <= reload_q; // see RULE8
      end else if (wr_count) begin
        count_q <= wdata;
      end else if (inc) begin
        count_q <= count_q + 16'h0001;
      end
      if (wr_reload) begin
        reload_q <= wdata;
      end
      if (roll && !baud_mode) begin
        ovf_flag_q <= 1'b1; // see RULE11
      end else if (clr_ovf) begin
        ovf_flag_q <= 1'b0;
      end
      if (ext_enable && ext_fall) begin
        ext_flag_q <= 1'b1; // see RULE12
      end else if (clr_ext) begin
        ext_flag_q <= 1'b0;
      end
    end
  end
endmodule // sbsm_timer2

// ### rtl/sbsm_top.v
// Serial bit-rate sources and shift-register mode with Avalon-MM registers
`timescale 1ns/100ps
`include "sbsm_defines.vh"

// How it works
// RULE1: shift mode runs one bit per machine cycle, oscillator over twelve.
// RULE2: fixed nine-bit mode divides oscillator by 64, or 32 with doubling.
// RULE3: timer 1 source gives overflow rate over 32, halved divisor when doubled.
// RULE4: software usually runs timer 1 in 8-bit auto-reload for the rate.
// RULE5: software keeps timer 1 interrupt off unless it reloads for slow rates.
// RULE6: either clock select bit puts timer 2 in bit-rate generator operation.
// RULE7: each select picks timer 1 or timer 2 for its own direction.
// RULE8: in generator operation each rollover reloads all sixteen timer 2 bits.
// RULE9: timer 2 source gives overflow rate over sixteen.
// RULE10: in generator operation with count select clear, timer 2 counts every state time.
// RULE11: generator rollovers set no overflow flag.
// RULE12: in generator operation an enabled external falling edge sets external flag without reloading timer 2.
// RULE13: software leaves timer 2 alone while it runs as generator.
// RULE14: shift mode moves eight bits LSB first on data line, device clocks.
// RULE15: buffer write loads marker, transmit active one machine cycle later.
// RULE16: shift clock low in S3 to S5, high in S6, S1, S2.
// RULE17: transmit register shifts right at S6P2, zeros in from left.
// RULE18: after last shift, transmit ends and done flag sets at S1P1.
// RULE19: reception starts when enabled and done flag clear, preloads 11111110.
// RULE20: receiver samples at S5P2 and shifts left at S6P2.
// RULE21: marker at left ends reception, loads buffer, sets done at S1P1.
module sbsm_top (
  input wire core_clk, // Oscillator clock, 100 MHz
  input wire nrst, // Async reset, active low
  input wire [4:0] avs_address, // Register byte address
  input wire avs_read, // Read request
  input wire avs_write, // Write request
  input wire [31:0] avs_writedata, // Write data
  output reg [31:0] avs_readdata, // Read data
  output reg avs_waitrequest, // Stall, low for one cycle per access
  input wire timer1_overflow, // Timer 1 overflow pulse, same clock
  input wire timer2_external_input, // External pin, falling edge event
  input wire timer2_count_input, // External pin for counter operation
  input wire serial_data_in, // Data line level from pin
  output reg serial_data_out, // Data line drive value
  output reg serial_data_oe, // Data line drive enable
  output reg serial_clock_out, // Shift clock pin
  output reg tx_baud_tick, // Transmit bit-time pulse
  output reg rx_baud_tick // Receive bit-time pulse
);
  wire [3:0] phase;
  wire state_tick;
  wire cycle_tick;
  wire [15:0] t2_count;
  wire [15:0] t2_reload;
  wire t2_ovf;
  wire t2_ovf_flag;
  wire t2_ext_flag;

  reg [8:0] ctrl_q;
  reg wait_q;
  reg [31:0] rdata_d;
  reg [2:0] ext_sync_q;
  reg [2:0] cnt_sync_q;
  reg [1:0] din_sync_q;
  reg din_sample_q;
  reg [8:0] tx_sh_q;
  reg [8:0] tx_sh_d;
  reg tx_pend_q;
  reg tx_armed_q;
  reg tx_active_q;
  reg tx_last_q;
  reg tx_done_q;
  reg [7:0] rx_sh_q;
  reg rx_go_q;
  reg rx_active_q;
  reg rx_last_q;
  reg rx_done_q;
  reg [7:0] rx_buf_q;
  reg sclk_d;

  wire [1:0] mode;
  wire shift_mode;
  wire baud_mode;
  wire wr_fire;
  wire rd_fire;
  wire wr_ctrl;
  wire wr_status;
  wire wr_data;
  wire ext_fall;
  wire cnt_fall;
  wire at_s1p1;
  wire at_s6p2;
  wire tx_active_d;

  assign mode = ctrl_q[`SBSM_CTRL_MODE_HI:`SBSM_CTRL_MODE_LO];
  assign shift_mode = (mode == `SBSM_MODE_SHIFT);
  assign baud_mode = ctrl_q[`SBSM_CTRL_TX_SEL] | ctrl_q[`SBSM_CTRL_RX_SEL]; // see RULE6
  assign wr_fire = avs_write & ~wait_q;
  assign rd_fire = avs_read & ~wait_q;
  assign wr_ctrl = wr_fire & (avs_address == `SBSM_OFF_CTRL);
  assign wr_status = wr_fire & (avs_address == `SBSM_OFF_STATUS);
  assign wr_data = wr_fire & (avs_address == `SBSM_OFF_DATA);
  assign ext_fall = ext_sync_q[2] & ~ext_sync_q[1];
  assign cnt_fall = cnt_sync_q[2] & ~cnt_sync_q[1];
  assign at_s1p1 = (phase == `SBSM_PH_S1P1);
  assign at_s6p2 = cycle_tick;

  sbsm_phase u_phase (
    .core_clk(core_clk),
    .nrst(nrst),
    .phase_q(phase),
    .state_tick_q(state_tick),
    .cycle_tick_q(cycle_tick)
  );

  sbsm_timer2 u_timer2 (
    .core_clk(core_clk),
    .nrst(nrst),
    .state_tick(state_tick),
    .cycle_tick(cycle_tick),
    .baud_mode(baud_mode),
    .run(ctrl_q[`SBSM_CTRL_T2_RUN]),
    .count_select(ctrl_q[`SBSM_CTRL_T2_CNT]),
    .ext_enable(ctrl_q[`SBSM_CTRL_T2_EXEN]),
    .ext_fall(ext_fall),
    .count_fall(cnt_fall),
    .wr_count(wr_fire & (avs_address == `SBSM_OFF_T2COUNT)),
    .wr_reload(wr_fire & (avs_address == `SBSM_OFF_T2RELOAD)),
    .wdata(avs_writedata[15:0]),
    .clr_ovf(wr_status & avs_writedata[`SBSM_ST_T2_OVF]),
    .clr_ext(wr_status & avs_writedata[`SBSM_ST_T2_EXT]),
    .count_q(t2_count),
    .reload_q(t2_reload),
    .ovf_pulse_q(t2_ovf),
    .ovf_flag_q(t2_ovf_flag),
    .ext_flag_q(t2_ext_flag)
  );

  // Read mux
  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `SBSM_OFF_CTRL: begin
        rdata_d[8:0] = ctrl_q;
      end
      `SBSM_OFF_STATUS: begin
        rdata_d[`SBSM_ST_RX_DONE] = rx_done_q;
        rdata_d[`SBSM_ST_TX_DONE] = tx_done_q;
        rdata_d[`SBSM_ST_T2_OVF] = t2_ovf_flag;
        rdata_d[`SBSM_ST_T2_EXT] = t2_ext_flag;
        rdata_d[`SBSM_ST_TX_ACT] = tx_active_q;
        rdata_d[`SBSM_ST_RX_ACT] = rx_active_q;
      end
      `SBSM_OFF_DATA: begin
        rdata_d[7:0] = rx_buf_q;
      end
      `SBSM_OFF_T2COUNT: begin
        rdata_d[15:0] = t2_count;
      end
      `SBSM_OFF_T2RELOAD: begin
        rdata_d[15:0] = t2_reload;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Bus slave: one wait cycle, then the access completes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_q <= `SBSM_CTRL_RESET; // see RULE2
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      avs_waitrequest <= ~((avs_read | avs_write) & wait_q);
      if ((avs_read | avs_write) && wait_q) begin
        avs_readdata <= rdata_d;
      end
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata[8:0];
      end
    end
  end

  // Pin synchronisers
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync_q <= 3'h7;
      cnt_sync_q <= 3'h7;
      din_sync_q <= 2'h3;
      din_sample_q <= 1'b1;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], timer2_external_input};
      cnt_sync_q <= {cnt_sync_q[1:0], timer2_count_input};
      din_sync_q <= {din_sync_q[0], serial_data_in};
      if (phase == `SBSM_PH_S5P2) begin
        din_sample_q <= din_sync_q[1]; // see RULE20
      end
    end
  end

  // Bit-rate pulse generators, index 0 transmit, 1 receive
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_baud
      reg [6:0] div_cnt_q;
      reg [6:0] div;
      reg src;
      wire use_t2;
      wire tick;
      assign use_t2 = ctrl_q[`SBSM_CTRL_TX_SEL + gi];
      always @* begin
        div = `SBSM_DIV_SHIFT;
        src = 1'b0;
        case (mode)
          `SBSM_MODE_SHIFT: begin
            src = cycle_tick; // see RULE1
            div = `SBSM_DIV_SHIFT;
          end
          `SBSM_MODE_FIX9: begin
            src = 1'b1;
            div = ctrl_q[`SBSM_CTRL_DOUBLE] ? `SBSM_DIV_FIX_FAST :
              `SBSM_DIV_FIX_SLOW; // see RULE2
          end
          default: begin
            if (use_t2) begin
              src = t2_ovf; // see RULE7
              div = `SBSM_DIV_T2; // see RULE9
            end else begin
              src = timer1_overflow; // see RULE7
              div = ctrl_q[`SBSM_CTRL_DOUBLE] ? `SBSM_DIV_T1_FAST :
                `SBSM_DIV_T1_SLOW; // see RULE3
            end
          end
        endcase
      end
      assign tick = src & (div_cnt_q >= div - 7'h01);
      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          div_cnt_q <= 7'h00;
        end else if (wr_ctrl) begin
          div_cnt_q <= 7'h00;
        end else if (tick) begin
          div_cnt_q <= 7'h00;
        end else if (src) begin
          div_cnt_q <= div_cnt_q + 7'h01;
        end
      end
    end
  endgenerate

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
    end else begin
      tx_baud_tick <= g_baud[0].tick;
      rx_baud_tick <= g_baud[1].tick;
    end
  end

  // Transmit register next value
  always @* begin
    tx_sh_d = tx_sh_q;
    if (wr_data) begin
      tx_sh_d = {`SBSM_TX_MARK, avs_writedata[7:0]}; // see RULE15
    end else if (at_s6p2 && tx_active_q) begin
      tx_sh_d = {1'b0, tx_sh_q[8:1]}; // see RULE17
    end
  end

  assign tx_active_d = (tx_active_q & ~(tx_last_q & at_s1p1)) |
    (tx_armed_q & at_s6p2);

  // Shift-mode transmitter
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_q <= 9'h000;
      tx_pend_q <= 1'b0;
      tx_armed_q <= 1'b0;
      tx_active_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      tx_sh_q <= tx_sh_d;
      if (wr_data && shift_mode) begin
        tx_pend_q <= 1'b1;
      end else if (at_s6p2) begin
        tx_pend_q <= 1'b0;
      end
      if (at_s6p2) begin
        tx_armed_q <= tx_pend_q & ~tx_active_q; // see RULE15
      end
      tx_active_q <= tx_active_d;
      if (at_s6p2 && tx_active_q && tx_sh_q[8:1] == 8'h01) begin
        tx_last_q <= 1'b1; // see RULE18
      end else if (at_s1p1) begin
        tx_last_q <= 1'b0;
      end
      if (tx_last_q && at_s1p1) begin
        tx_done_q <= 1'b1; // see RULE18
      end else if (wr_status && avs_writedata[`SBSM_ST_TX_DONE]) begin
        tx_done_q <= 1'b0;
      end
    end
  end

  // Shift-mode receiver
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh_q <= 8'h00;
      rx_go_q <= 1'b0;
      rx_active_q <= 1'b0;
      rx_last_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_buf_q <= 8'h00;
    end else begin
      rx_go_q <= 1'b0;
      if (at_s6p2 && shift_mode && ctrl_q[`SBSM_CTRL_RX_EN] && !rx_done_q &&
          !rx_active_q && !rx_go_q) begin
        rx_sh_q <= `SBSM_RX_FILL; // see RULE19
        rx_go_q <= 1'b1;
      end else if (at_s6p2 && rx_active_q && !rx_last_q) begin
        rx_sh_q <= {rx_sh_q[6:0], din_sample_q}; // see RULE20
        if (!rx_sh_q[7]) begin
          rx_last_q <= 1'b1; // see RULE21
          // First bit taken in sits at bit 6, reversed so it lands at bit 0
          rx_buf_q <= {din_sample_q, rx_sh_q[0], rx_sh_q[1], rx_sh_q[2], rx_sh_q[3],
            rx_sh_q[4], rx_sh_q[5], rx_sh_q[6]}; // see RULE14
        end
      end
      if (rx_go_q) begin
        rx_active_q <= 1'b1; // see RULE19
      end else if (rx_last_q && at_s1p1) begin
        rx_active_q <= 1'b0; // see RULE21
        rx_last_q <= 1'b0;
      end
      if (rx_last_q && at_s1p1) begin
        rx_done_q <= 1'b1; // see RULE21
      end else if (wr_status && avs_writedata[`SBSM_ST_RX_DONE]) begin
        rx_done_q <= 1'b0;
      end
    end
  end

  // Shift clock and data line drive
  always @* begin
    sclk_d = 1'b1;
    if (tx_active_d || rx_active_q || rx_go_q) begin
      // Low while the next phase is in S3..S5
      sclk_d = ~((phase >= `SBSM_PH_S2P2) && (phase < `SBSM_PH_S5P2)); // see RULE16
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serial_clock_out <= 1'b1;
      serial_data_out <= 1'b1;
      serial_data_oe <= 1'b0;
    end else begin
      serial_clock_out <= sclk_d; // see RULE14
      serial_data_out <= tx_sh_d[0]; // see RULE14
      serial_data_oe <= tx_active_d;
    end
  end
endmodule // sbsm_top

// ### bench/sbsm_properties.sv
// Assertion checker for the serial bit-rate and shift-mode block
`timescale 1ns/100ps
`include "sbsm_defines.vh"
module sbsm_properties (
  input wire core_clk, // Clock
  input wire nrst, // Reset, active low
  input wire [4:0] avs_address, // Address
  input wire avs_read, // Read
  input wire avs_write, // Write
  input wire [31:0] avs_writedata, // Write data
  input wire [31:0] avs_readdata, // Read data
  input wire avs_waitrequest, // Stall
  input wire timer1_overflow, // Timer 1 pulse
  input wire timer2_external_input, // External pin
  input wire timer2_count_input, // Count pin
  input wire serial_data_in, // Data line in
  input wire serial_data_out, // Data line out
  input wire serial_data_oe, // Data line enable
  input wire serial_clock_out, // Shift clock
  input wire tx_baud_tick, // Tx tick
  input wire rx_baud_tick // Rx tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  reg [7:0] oe_len_q;
  // Length of the current transmit frame in clocks
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      oe_len_q <= 8'h00;
    else if (serial_data_oe)
      oe_len_q <= oe_len_q + 8'h01;
    else
      oe_len_q <= 8'h00;
  end
  wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in the next cycle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address != 5'h00 &&
    avs_address != 5'h04 && avs_address != 5'h08 && avs_address != 5'h0C &&
    avs_address != 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  clk_low_span_a: assert property (
    $fell(serial_clock_out) |-> !serial_clock_out [*6] ##1 serial_clock_out)
    else $error("shift clock low phase not six clocks");
  clk_high_span_a: assert property ($rose(serial_clock_out) |-> serial_clock_out [*6])
    else $error("shift clock high phase too short");
  machine_cycle_a: assert property (
    $fell(serial_clock_out) |-> ##12 (serial_clock_out || $fell(serial_clock_out)))
    else $error("shift clock period not twelve clocks");
  tx_start_a: assert property (
    $rose(serial_data_oe) |-> serial_clock_out [*4] ##1 !serial_clock_out)
    else $error("transmit not started at end of machine cycle");
  tx_frame_len_a: assert property (
    $fell(serial_data_oe) |-> oe_len_q >= 8'h60 && oe_len_q <= 8'h62)
    else $error("transmit frame length wrong");
  data_hold_a: assert property (
    serial_data_oe && !serial_clock_out |-> $stable(serial_data_out))
    else $error("data changed while shift clock low");
  tick_pulse_a: assert property (tx_baud_tick |=> !tx_baud_tick)
    else $error("bit-time tick longer than one clock");
endmodule // sbsm_properties

// ### bench/sbsm_shift_partner.sv
// Shift-register peripheral on the far side of the serial data line
`timescale 1ns/100ps
module sbsm_shift_partner (
  input wire shift_clk, // Shift clock from device
  input wire line_in, // Data line level
  input wire dev_oe, // Device drives the line
  input wire send_en, // Peripheral offers a byte
  input wire [7:0] send_byte, // Byte offered, LSB first
  output reg [7:0] got_byte_q, // Last eight bits taken in
  output wire drv_en, // Peripheral drives the line
  output wire drv_bit // Level driven
);
  reg [2:0] idx_q;
  initial got_byte_q = 8'h00;
  // Takes device bits on the rising shift clock, LSB first
  always @(posedge shift_clk) begin
    if (dev_oe)
      got_byte_q <= {line_in, got_byte_q[7:1]};
  end
  // Next bit after each rising edge, device sampled the old one
  always @(posedge shift_clk or negedge send_en) begin
    if (!send_en)
      idx_q <= 3'h0;
    else if (!dev_oe)
      idx_q <= idx_q + 3'h1;
  end
  assign drv_en = send_en && !dev_oe;
  assign drv_bit = send_byte[idx_q];
endmodule // sbsm_shift_partner

// ### bench/serial_baud_and_shift_mode_tb_top.sv
// Self-checking testbench for the serial bit-rate and shift-mode block
`timescale 1ns/100ps
`include "sbsm_defines.vh"
module serial_baud_and_shift_mode_tb_top;
  typedef struct packed {logic [31:0] ctrl; logic [31:0] tx_per; logic [31:0] rx_per;} sbsm_row_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic timer1_overflow = 1'b0;
  logic [1:0] t1_div_q = 2'h0;
  logic t2_ext = 1'b1;
  logic p_en = 1'b0;
  logic [7:0] p_byte = 8'h00;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, serial_data_out, serial_data_oe, serial_clock_out;
  wire tx_baud_tick, rx_baud_tick, serial_data_in, p_drv_en, p_drv_bit;
  wire [7:0] p_got;
  int mismatches = 0;
  int check_count = 0;
  int per;
  logic [31:0] rdata;
  sbsm_row_t rows [8] = '{'{32'h000, 32'hC, 32'hC}, '{32'h002, 32'h40, 32'h40},
    '{32'h00A, 32'h20, 32'h20}, '{32'h001, 32'h80, 32'h80}, '{32'h009, 32'h40, 32'h40},
    '{32'h051, 32'h40, 32'h80}, '{32'h061, 32'h80, 32'h40}, '{32'h07B, 32'h40, 32'h40}};
  // Line pulled up when nobody drives it
  assign serial_data_in = serial_data_oe ? serial_data_out : (p_drv_en ? p_drv_bit : 1'b1);
  always #5 core_clk = ~core_clk;
  // Timer 1 in auto-reload overflows every four clocks
  always @(posedge core_clk) begin
    t1_div_q <= t1_div_q + 2'h1;
    timer1_overflow <= (t1_div_q == 2'h3);
  end
  sbsm_top i_dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer1_overflow(timer1_overflow), .timer2_external_input(t2_ext),
    .timer2_count_input(1'b1), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .serial_clock_out(serial_clock_out), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick));
  sbsm_shift_partner i_partner (.shift_clk(serial_clock_out), .line_in(serial_data_in),
    .dev_oe(serial_data_oe), .send_en(p_en), .send_byte(p_byte), .got_byte_q(p_got),
    .drv_en(p_drv_en), .drv_bit(p_drv_bit));
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task timeout(input string what);
    mismatches++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    print_verdict();
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) timeout("bus");
  endtask
  task poll(input logic [31:0] mask, input string what);
    int n;
    n = 0;
    do begin
      bus(1'b0, `SBSM_OFF_STATUS, 32'h0);
      n++;
    end while ((rdata & mask) === 32'h0 && n < 80);
    if (n >= 80) timeout(what);
  endtask
  // Clocks between two ticks of one direction
  task period(input logic rx, output int p);
    int n;
    n = 0;
    p = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((rx ? rx_baud_tick : tx_baud_tick) !== 1'b1 && n < 600);
    do begin
      @(posedge core_clk);
      p++;
    end while ((rx ? rx_baud_tick : tx_baud_tick) !== 1'b1 && p < 600);
    if (p >= 600) timeout("tick");
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    timeout("run");
  end
  initial begin
    repeat (2) @(posedge core_clk);
    check("oe in reset", serial_data_oe, 32'h0);
    check("clock in reset", serial_clock_out, 32'h1);
    nrst <= 1'b1;
    bus(1'b0, `SBSM_OFF_CTRL, 32'h0);
    check("ctrl reset", rdata, 32'h0);
    bus(1'b1, `SBSM_OFF_T2RELOAD, 32'hFFFE);
    bus(1'b1, `SBSM_OFF_T2COUNT, 32'hFFFE);
    bus(1'b0, `SBSM_OFF_T2RELOAD, 32'h0);
    check("reload", rdata, 32'hFFFE);
    bus(1'b1, 5'h14, 32'hFFFFFFFF);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped", rdata, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, `SBSM_OFF_CTRL, rows[i].ctrl);
      period(1'b0, per);
      check("tx period", per, rows[i].tx_per);
      period(1'b1, per);
      check("rx period", per, rows[i].rx_per);
    end
    bus(1'b1, `SBSM_OFF_CTRL, 32'h17B);
    t2_ext <= 1'b0;
    repeat (4) @(posedge core_clk);
    t2_ext <= 1'b1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, `SBSM_OFF_STATUS, 32'h0);
    check("ext flag", rdata[3], 32'h1);
    check("ovf flag", rdata[2], 32'h0);
    period(1'b0, per);
    check("tx period ext", per, 32'h40);
    bus(1'b1, `SBSM_OFF_STATUS, 32'hF);
    bus(1'b1, `SBSM_OFF_CTRL, 32'h0);
    bus(1'b1, `SBSM_OFF_DATA, 32'hA5);
    poll(32'h2, "tx done");
    check("tx active", rdata[4], 32'h0);
    check("tx byte", p_got, 32'hA5);
    bus(1'b1, `SBSM_OFF_STATUS, 32'h3);
    p_byte <= 8'h35;
    p_en <= 1'b1;
    bus(1'b1, `SBSM_OFF_CTRL, 32'h4);
    poll(32'h1, "rx done");
    check("rx window", rdata[5], 32'h0);
    bus(1'b1, `SBSM_OFF_CTRL, 32'h0);
    p_en <= 1'b0;
    bus(1'b0, `SBSM_OFF_DATA, 32'h0);
    check("rx byte", rdata, 32'h35);
    bus(1'b1, `SBSM_OFF_DATA, 32'h5A);
    repeat (30) @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("oe after reset", serial_data_oe, 32'h0);
    check("wait after reset", avs_waitrequest, 32'h1);
    nrst <= 1'b1;
    bus(1'b0, `SBSM_OFF_CTRL, 32'h0);
    check("ctrl after reset", rdata, 32'h0);
    print_verdict();
  end
endmodule // serial_baud_and_shift_mode_tb_top
bind sbsm_top sbsm_properties i_props (.core_clk(core_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer1_overflow(timer1_overflow),
  .timer2_external_input(timer2_external_input), .timer2_count_input(timer2_count_input),
  .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .serial_clock_out(serial_clock_out),
  .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick));
